// ---- src/kvmsc_top.sv ----
`timescale 1ns/1ps
// Function
// - Link is 19200 baud, 8 data bits, no parity, 1 stop bit.
// - No flow control; bytes are accepted without any handshake.
// - Every valid switching code received is echoed on the serial output.
// - Each byte is one command selecting a user and one of 24 hosts.
// - Hosts 1-16 code as user digit high, port minus one low.
// - Hosts 17-24 use the 6x/8x table, 4/19 is A8; video off 71-74.
// - Each user selection is held independently of the others.
// - Any switch of a channel transmits its code for slave units.
// - A valid received code performs the same channel change.
module kvmsc_top
(
   input  wire logic        CLOCK_I,
   input  wire logic        RST_I,
   input  wire logic        RXD_I,
   input  wire logic        LOCAL_SEL_I,
   input  wire logic [1:0]  LOCAL_USER_I,
   input  wire logic [4:0]  LOCAL_HOST_I,
   output logic             TXD_O,
   output logic [19:0]      USER_HOST_O,
   output logic             SWITCH_O
);
   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   kvmsc_pkg::kvmsc_state_t rx_st_q;
   logic [15:0] rx_cnt_q;
   logic [2:0]  rx_bit_q;
   logic [7:0]  rx_sh_q;
   logic        rx_done_q;
   logic [7:0]  rx_byte_q;

   wire logic rx_tick = (rx_cnt_q == 16'h0000);
   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         rx_st_q   <= kvmsc_pkg::KVMSC_IDLE;
         rx_cnt_q  <= 16'h0000;
         rx_bit_q  <= 3'h0;
         rx_sh_q   <= 8'h00;
         rx_done_q <= 1'b0;
         rx_byte_q <= 8'h00;
      end
      else
      begin
         rx_done_q <= 1'b0;
         if (!rx_tick)
            rx_cnt_q <= rx_cnt_q - 16'h0001;
         unique case (rx_st_q)
            kvmsc_pkg::KVMSC_IDLE:
               if (!RXD_I)
               begin
                  rx_st_q  <= kvmsc_pkg::KVMSC_START;
                  rx_cnt_q <= 16'(kvmsc_pkg::HALF_CYCLES - 1);
               end
            kvmsc_pkg::KVMSC_START:
               if (rx_tick)
               begin
                  // A glitch shorter than half a bit is not a start
                  rx_st_q  <= RXD_I ? kvmsc_pkg::KVMSC_IDLE : kvmsc_pkg::KVMSC_DATA;
                  rx_cnt_q <= 16'(kvmsc_pkg::BIT_CYCLES - 1);
                  rx_bit_q <= 3'h0;
               end
            kvmsc_pkg::KVMSC_DATA:
               if (rx_tick)
               begin
                  rx_sh_q  <= {RXD_I, rx_sh_q[7:1]};
                  rx_cnt_q <= 16'(kvmsc_pkg::BIT_CYCLES - 1);
                  rx_bit_q <= rx_bit_q + 3'h1;
                  if (rx_bit_q == 3'(kvmsc_pkg::DATA_BITS - 1))
                     rx_st_q <= kvmsc_pkg::KVMSC_STOP;
               end
            kvmsc_pkg::KVMSC_STOP:
               if (rx_tick)
               begin
                  // Framing errors drop the byte silently
                  rx_st_q   <= kvmsc_pkg::KVMSC_IDLE;
                  rx_done_q <= RXD_I;
                  rx_byte_q <= rx_sh_q;
               end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Decode and selection
   // ---------------------------------------------------------------
   kvmsc_pkg::kvmsc_cmd_t rx_cmd;
   logic [7:0] tx_code;
   wire logic       loc_ok   = LOCAL_SEL_I &&
                               (LOCAL_HOST_I < 5'(kvmsc_pkg::NUM_HOSTS) ||
                                LOCAL_HOST_I == kvmsc_pkg::HOST_OFF);
   // Serial commands win over a simultaneous local request
   wire logic       rx_go    = rx_done_q && rx_cmd.valid;
   wire logic       do_sw    = rx_go || loc_ok;
   wire logic [1:0] sw_user  = rx_go ? rx_cmd.user : LOCAL_USER_I;
   wire logic [4:0] sw_host  = rx_go ? rx_cmd.host : LOCAL_HOST_I;

   kvmsc_codec i_kvmsc_codec
   (
      .code_i (rx_byte_q),
      .cmd_o  (rx_cmd),
      .user_i (sw_user),
      .host_i (sw_host),
      .code_o (tx_code)
   );

   logic [4:0] sel_q [kvmsc_pkg::NUM_USERS];
   genvar gi;
   generate
      for (gi = 0; gi < kvmsc_pkg::NUM_USERS; gi++)
      begin : g_user
         always_ff @(posedge CLOCK_I or posedge RST_I)
         begin
            if (RST_I)
               sel_q[gi] <= kvmsc_pkg::HOST_RESET;
            else if (do_sw && sw_user == 2'(gi))
               sel_q[gi] <= sw_host;
         end
         assign USER_HOST_O[gi*5 +: 5] = sel_q[gi];
      end
   endgenerate

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
         SWITCH_O <= 1'b0;
      else
         SWITCH_O <= do_sw;
   end

   // ---------------------------------------------------------------
   // Transmitter (echo and announce share one code word)
   // ---------------------------------------------------------------
   // One pending slot: a code arriving while sending overwrites the older
   // pending one; at one byte per frame from the link this cannot happen.
   logic       pend_q;
   logic [7:0] pend_code_q;
   logic       tx_busy_q;
   logic [9:0] tx_sh_q;
   logic [3:0] tx_n_q;
   logic [15:0] tx_cnt_q;
   wire logic  tx_tick = (tx_cnt_q == 16'h0000);
   wire logic  tx_load = pend_q && !tx_busy_q;

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         pend_q      <= 1'b0;
         pend_code_q <= 8'h00;
      end
      else if (do_sw)
      begin
         pend_q      <= 1'b1;
         pend_code_q <= tx_code;
      end
      else if (tx_load)
         pend_q <= 1'b0;
   end

   always_ff @(posedge CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         tx_busy_q <= 1'b0;
         tx_sh_q   <= 10'h3FF;
         tx_n_q    <= 4'h0;
         tx_cnt_q  <= 16'h0000;
         TXD_O     <= kvmsc_pkg::LINE_IDLE;
      end
      else if (tx_load)
      begin
         tx_busy_q <= 1'b1;
         tx_sh_q   <= {1'b1, pend_code_q, 1'b0};
         tx_n_q    <= 4'(kvmsc_pkg::DATA_BITS + kvmsc_pkg::STOP_BITS + 1);
         tx_cnt_q  <= 16'h0000;
      end
      else if (tx_busy_q)
      begin
         if (tx_tick)
         begin
            if (tx_n_q == 4'h0)
            begin
               tx_busy_q <= 1'b0;
               TXD_O     <= kvmsc_pkg::LINE_IDLE;
            end
            else
            begin
               TXD_O    <= tx_sh_q[0];
               tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
               tx_n_q   <= tx_n_q - 4'h1;
               tx_cnt_q <= 16'(kvmsc_pkg::BIT_CYCLES - 1);
            end
         end
         else
            tx_cnt_q <= tx_cnt_q - 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_invalid_no_change: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (rx_done_q && !rx_cmd.valid && !loc_ok) |=> !SWITCH_O && $stable(pend_code_q))
      else $error("invalid byte caused a switch");
   chk_valid_echo_queued: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      rx_go |=> pend_q && pend_code_q == $past(rx_byte_q))
      else $error("valid code not queued for echo");
   chk_valid_applies: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      rx_go |=> sel_q[$past(rx_cmd.user)] == $past(rx_cmd.host))
      else $error("valid code did not switch");
   chk_others_held: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (do_sw && sw_user != 2'h0) |=> $stable(sel_q[0]))
      else $error("other user selection changed");
   chk_switch_announce: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      SWITCH_O |-> pend_q || tx_busy_q)
      else $error("switch not announced");
   chk_start_bit_low: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (tx_busy_q && tx_tick && tx_n_q == 4'hA) |=> !TXD_O [*8])
      else $error("start bit missing");
   chk_stop_bit_high: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      (tx_busy_q && tx_tick && tx_n_q == 4'h1) |=> TXD_O)
      else $error("stop bit not high");
   chk_idle_high: assert property (@(posedge CLOCK_I) disable iff (RST_I)
      !tx_busy_q |-> TXD_O)
      else $error("line not idle high");

   cov_serial_switch: cover property (@(posedge CLOCK_I) disable iff (RST_I) rx_go);
   cov_local_switch:  cover property (@(posedge CLOCK_I) disable iff (RST_I) loc_ok && !rx_go);
   cov_bad_byte:      cover property (@(posedge CLOCK_I) disable iff (RST_I)
      rx_done_q && !rx_cmd.valid);
   cov_video_off:     cover property (@(posedge CLOCK_I) disable iff (RST_I)
      rx_go && rx_cmd.host == kvmsc_pkg::HOST_OFF);

endmodule : kvmsc_top

// ---- src/kvmsc_pkg.sv ----
package kvmsc_pkg;

   // ---------------------------------------------------------------
   // Link timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned BAUD_BPS      = 19200;
   localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_BPS;
   localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
   localparam int unsigned DATA_BITS     = 8;
   localparam int unsigned STOP_BITS     = 1;

   // ---------------------------------------------------------------
   // Selection encoding
   // ---------------------------------------------------------------
   localparam int unsigned NUM_USERS     = 4;
   localparam int unsigned NUM_HOSTS     = 24;
   localparam logic [4:0]  HOST_OFF      = 5'h1F;
   localparam logic [4:0]  HOST_RESET    = 5'h1F;
   localparam logic        LINE_IDLE     = 1'b1;

   typedef struct packed {
      logic       valid;
      logic [1:0] user;
      logic [4:0] host;
   } kvmsc_cmd_t;

   typedef enum logic [1:0] {
      KVMSC_IDLE  = 2'b00,
      KVMSC_START = 2'b01,
      KVMSC_DATA  = 2'b11,
      KVMSC_STOP  = 2'b10
   } kvmsc_state_t;

endpackage : kvmsc_pkg

// ---- src/kvmsc_codec.sv ----
`timescale 1ns/1ps
// Pure code table: byte to (user, host) and back. host 0..23, HOST_OFF = video off.
module kvmsc_codec
(
   input  wire logic [7:0]        code_i,
   output kvmsc_pkg::kvmsc_cmd_t  cmd_o,
   input  wire logic [1:0]        user_i,
   input  wire logic [4:0]        host_i,
   output logic      [7:0]        code_o
);
   wire logic [3:0] hi = code_i[7:4];
   wire logic [3:0] lo = code_i[3:0];
   wire logic       low16 = (hi >= 4'h1) && (hi <= 4'h4);
   wire logic       u12hi = (hi == 4'h6);
   wire logic       u34hi = (hi == 4'h8) && (code_i != 8'h8A);
   wire logic       odd19 = (code_i == 8'hA8);
   wire logic       voff  = (hi == 4'h7) && (lo >= 4'h1) && (lo <= 4'h4);

   assign cmd_o.valid = low16 | u12hi | u34hi | odd19 | voff;
   assign cmd_o.user  = low16 ? 2'(hi - 4'h1) :
                        voff  ? 2'(lo - 4'h1) :
                        odd19 ? 2'h3 : {u34hi, lo[3]};
   assign cmd_o.host  = low16 ? {1'b0, lo} :
                        voff  ? kvmsc_pkg::HOST_OFF :
                        odd19 ? 5'h12 : {2'b10, lo[2:0]};

   wire logic [2:0] hh = host_i[2:0];
   assign code_o = (host_i == kvmsc_pkg::HOST_OFF) ? {4'h7, 2'h0, user_i} + 8'h01 :
                   !host_i[4] ? {2'h0, user_i, host_i[3:0]} + 8'h10 :
                   (user_i == 2'h3 && hh == 3'h2) ? 8'hA8 :
                   {user_i[1] ? 4'h8 : 4'h6, user_i[0], hh};
endmodule : kvmsc_codec

// ---- tb/kvmsc_remote_model.sv ----
`timescale 1ns/1ps
// Remote controller: sends 8N1 bytes with no handshake and collects each byte that comes back with a high stop bit
module kvmsc_remote_model
(
   input  wire logic clk_i,
   input  wire logic line_i,
   output logic      line_o
);
   localparam int BIT = kvmsc_pkg::BIT_CYCLES;
   logic [7:0] rx_q[$];

   initial line_o = 1'b1;

   task automatic send(input logic [7:0] b);
      line_o <= 1'b0;
      repeat (BIT) @(posedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
         line_o <= b[i];
         repeat (BIT) @(posedge clk_i);
      end
      line_o <= 1'b1;
      repeat (BIT) @(posedge clk_i);
   endtask : send

   // Bytes with a bad stop bit are dropped; the start bit is not rechecked, so a stray glitch on an idle line is collected as FF
   initial
   begin
      logic [7:0] b;
      forever
      begin
         @(posedge clk_i);
         if (line_i === 1'b0)
         begin
            repeat (BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++)
            begin
               repeat (BIT) @(posedge clk_i);
               b[i] = line_i;
            end
            repeat (BIT) @(posedge clk_i);
            if (line_i === 1'b1)
               rx_q.push_back(b);
         end
      end
   end
endmodule : kvmsc_remote_model

// ---- tb/tb_kvmsc_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_kvmsc_top;
   logic clk, rst, rxd, lsel;
   logic [1:0] luser;
   logic [4:0] lhost, h;
   logic [7:0] exp_q[$];
   logic [4:0] exp_sel[4];
   logic [7:0] bad[3] = '{8'h00, 8'h8A, 8'h75};
   wire txd, sw;
   wire [19:0] uh;
   int fails = 0, checked = 0, cyc = 0, sw_cnt = 0, exp_sw = 0;
   logic [1:0] u;
   logic [7:0] got_b, exp_b;

   kvmsc_top i_kvmsc_top (.CLOCK_I(clk), .RST_I(rst), .RXD_I(rxd), .LOCAL_SEL_I(lsel),
      .LOCAL_USER_I(luser), .LOCAL_HOST_I(lhost), .TXD_O(txd), .USER_HOST_O(uh),
      .SWITCH_O(sw));
   kvmsc_remote_model i_kvmsc_remote_model (.clk_i(clk), .line_i(txd), .line_o(rxd));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Expectations
   // ---------------------------------------------------------------
   function automatic logic [7:0] code_of(input logic [1:0] u, input logic [4:0] h);
      logic [7:0] c;
      c = 8'h10 + {2'b00, u, 4'h0} + {3'h0, h};
      if (h >= 5'h10)
         c = 8'h50 + (u[1] ? 8'h20 : 8'h00) + (u[0] ? 8'h08 : 8'h00) + {3'h0, h};
      if (u == 2'h3 && h == 5'h12)
         c = 8'hA8;
      if (h == 5'h1F)
         c = 8'h71 + {6'h0, u};
      return c;
   endfunction : code_of

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (sw === 1'b1)
         sw_cnt <= sw_cnt + 1;
      if (cyc == 100000)
      begin
         fails++;
         final_report();
      end
   end

   task automatic final_report();
      if (fails == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   task automatic check_state();
      `CHK(uh, {exp_sel[3], exp_sel[2], exp_sel[1], exp_sel[0]})
      `CHK(sw_cnt, exp_sw)
   endtask : check_state

   task automatic apply(input logic ok, input logic [1:0] u, input logic [4:0] h);
      if (ok)
      begin
         exp_sel[u] = h;
         exp_q.push_back(code_of(u, h));
         exp_sw++;
      end
      check_state();
   endtask : apply

   task automatic ser(input logic [7:0] b, input logic ok, input logic [1:0] u,
                      input logic [4:0] h);
      i_kvmsc_remote_model.send(b);
      repeat (300) @(posedge clk);
      apply(ok, u, h);
   endtask : ser

   task automatic loc(input logic ok, input logic [1:0] u, input logic [4:0] h);
      luser <= u;
      lhost <= h;
      lsel <= 1'b1;
      @(posedge clk);
      lsel <= 1'b0;
      repeat (5300) @(posedge clk);
      apply(ok, u, h);
   endtask : loc

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      lsel = 1'b0;
      luser = 2'h0;
      lhost = 5'h00;
      void'($urandom(32'h784d0da9));
      foreach (exp_sel[i]) exp_sel[i] = 5'h1F;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check_state();
      ser(8'hA8, 1'b1, 2'h3, 5'h12);
      ser(8'h8F, 1'b1, 2'h3, 5'h17);
      ser(8'h1F, 1'b1, 2'h0, 5'h0F);
      for (int i = 0; i < 4; i++)
         ser(8'h71 + i[7:0], 1'b1, i[1:0], 5'h1F);
      foreach (bad[i]) ser(bad[i], 1'b0, 2'h0, 5'h00);
      for (int i = 0; i < 3; i++)
      begin
         u = 2'($urandom_range(3, 0));
         h = 5'($urandom_range(24, 0));
         if (h == 5'h18)
            h = 5'h1F;
         ser(code_of(u, h), 1'b1, u, h);
      end
      repeat (5300) @(posedge clk);
      loc(1'b1, 2'h2, 5'h10);
      loc(1'b0, 2'h1, 5'h18);
      loc(1'b1, 2'h0, 5'h17);
      repeat (300) @(posedge clk);
      `CHK(i_kvmsc_remote_model.rx_q.size(), exp_q.size())
      while (exp_q.size() > 0 && i_kvmsc_remote_model.rx_q.size() > 0)
      begin
         // Pop once: the compare macro evaluates its arguments twice
         got_b = i_kvmsc_remote_model.rx_q.pop_front();
         exp_b = exp_q.pop_front();
         `CHK(got_b, exp_b)
      end
      final_report();
   end
endmodule : tb_kvmsc_top
